// *** hw/lks_byte_cmp.sv ***
`timescale 1ns/10ps
module lks_byte_cmp (
  // Operands
  input wire logic [7:0] opnd1,
  input wire logic [7:0] opnd2,
  // Results
  output logic [4:0] ind,
  output logic equal
);

  logic [8:0] diff;

  always_comb begin
    diff = {1'b0, opnd2} - {1'b0, opnd1};
    ind = 5'h00;
    ind[lks_pkg::LKS_IND_CARRY] = diff[8];
    ind[lks_pkg::LKS_IND_OVFL] = (opnd2[7] != opnd1[7]) && (diff[7] != opnd2[7]);
    ind[lks_pkg::LKS_IND_EVEN] = ~diff[0];
    ind[lks_pkg::LKS_IND_NEG] = diff[7];
    ind[lks_pkg::LKS_IND_ZERO] = (diff[7:0] == 8'h00);
    equal = (diff[7:0] == 8'h00);
  end

endmodule

// *** hw/lks_exec.sv ***
// What this block does
// - Copy eleven storage words into selected level
// - Level comes from operand bits 14-15
// - IT and trace hold trace past next
// - IT clear, trace set: trace allowed immediately
// - Level exit with trace set: no trace
// - Current ADDRESS_KEY_REGISTER/LEVEL_STATUS_REGISTER touched only for same level
// - Addressing mode 01 adds two to base
// - Indicators untouched when level differs
// - Problem-state bad next fetch: protect check
// - Privileged ops in problem state: privilege check
// - Storage key from byte low nibble
// - Segment entry chosen by index and stack
// - Entry bits 7-12 give physical block
// - Invalid entry use raises invalid address
// - Problem-state write to read-only: protect
// - Segment load with translator off: invalid function
// - Scan subtracts byte, counts down register 7
// - Address steps by direction; stop on equal/end
// - Equal stop: address past, count kept
// - Restartable; zero count does nothing
// - Scan indicators from byte subtraction
// - Register 7 as operand: invalid function
// - Indicators sit in status high-order bits 0-4
`timescale 1ns/10ps
module lks_exec #(
  parameter int LSB_WORDS = lks_pkg::LKS_LSB_WORDS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction issue
  input wire logic start,
  input wire lks_pkg::lks_cmd_t cmd,
  input wire logic irq_pending,
  input wire logic next_instr_done,
  // Main storage
  output logic mem_req,
  output logic [15:0] mem_addr,
  output logic mem_byte,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [15:0] mem_rdata,
  // Next-fetch assignment probe
  output logic probe_req,
  output logic [15:0] probe_addr,
  input wire logic probe_bad,
  // Level block and status updates
  output logic lsb_wr,
  output logic [1:0] lsb_lvl,
  output logic [3:0] lsb_idx,
  output logic [15:0] lsb_dat,
  output logic cur_upd,
  output logic trace_suppress_flag,
  output logic ind_wr,
  output logic [4:0] ind,
  // Register writeback
  output logic reg_wr,
  output logic [2:0] reg_idx,
  output logic [15:0] reg_dat,
  output logic scan_wb,
  output logic [15:0] r2_new,
  output logic [15:0] r7_new,
  // Key and segment loads
  output logic key_wr,
  output logic [4:0] key_blk,
  output logic [3:0] key_val,
  output logic seg_wr,
  output logic [4:0] seg_idx,
  output logic [2:0] seg_stk,
  output logic [31:0] seg_dat,
  // Translation check
  input wire logic xl_req,
  input wire lks_pkg::lks_xl_t xl,
  output logic xl_done,
  output logic [5:0] xl_phys,
  output logic xl_isa,
  output logic xl_prot,
  // Completion
  output logic busy,
  output logic done,
  output lks_pkg::lks_chk_t chk
);

  typedef struct packed {
    lks_pkg::lks_state_t st;
    lks_pkg::lks_cmd_t c;
    logic [3:0] widx;
    logic [15:0] cnt;
    logic [15:0] addr;
    logic [15:0] lsr_w;
    logic [15:0] iar_w;
    logic [15:0] seg_hi;
    logic mem_req;
    logic mem_byte;
    logic [15:0] mem_addr;
    logic probe_req;
    logic [15:0] probe_addr;
    logic lsb_wr;
    logic [3:0] lsb_idx;
    logic [15:0] lsb_dat;
    logic cur_upd;
    logic trc;
    logic ind_wr;
    logic [4:0] ind;
    logic reg_wr;
    logic [2:0] reg_idx;
    logic [15:0] reg_dat;
    logic scan_wb;
    logic key_wr;
    logic [3:0] key_val;
    logic seg_wr;
    logic [31:0] seg_dat;
    logic xl_done;
    logic [5:0] xl_phys;
    logic xl_isa;
    logic xl_prot;
    logic done;
    logic busy;
    lks_pkg::lks_chk_t chk;
  } lks_reg_t;

  lks_reg_t s_r;
  lks_reg_t s_nxt;
  logic [4:0] cmp_ind;
  logic cmp_eq;
  logic [7:0] cmp_byte;

  // Bit n counted from the left of a word
  function automatic logic bitn(input logic [15:0] w, input int n);
    return w[15 - n];
  endfunction

  function automatic logic [15:0] step(input logic [15:0] a, input logic dec);
    return dec ? a - lks_pkg::LKS_STEP_BYTE : a + lks_pkg::LKS_STEP_BYTE;
  endfunction

  assign cmp_byte = mem_rdata[7:0];

  lks_byte_cmp u_cmp (
    .opnd1(s_r.c.r1_val[7:0]),
    .opnd2(cmp_byte),
    .ind(cmp_ind),
    .equal(cmp_eq)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.lsb_wr = 1'b0;
    s_nxt.cur_upd = 1'b0;
    s_nxt.ind_wr = 1'b0;
    s_nxt.reg_wr = 1'b0;
    s_nxt.scan_wb = 1'b0;
    s_nxt.key_wr = 1'b0;
    s_nxt.seg_wr = 1'b0;
    s_nxt.probe_req = 1'b0;
    s_nxt.xl_done = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.chk = '0;
    if (next_instr_done) begin
      s_nxt.trc = 1'b0;
    end
    // Translation checks run beside the instruction sequencer
    if (xl_req) begin
      s_nxt.xl_done = 1'b1;
      s_nxt.xl_phys = xl.entry[15 - lks_pkg::LKS_SEG_PHYS_MSB:
                               15 - lks_pkg::LKS_SEG_PHYS_LSB];
      s_nxt.xl_isa = ~bitn(xl.entry, lks_pkg::LKS_SEG_VALID_BIT);
      s_nxt.xl_prot = bitn(xl.entry, lks_pkg::LKS_SEG_VALID_BIT) &&
                      bitn(xl.entry, lks_pkg::LKS_SEG_RO_BIT) && xl.write &&
                      xl.problem && !xl.cycle_steal;
    end
    unique case (s_r.st)
      lks_pkg::ST_IDLE: begin
        if (start && cmd.op != lks_pkg::no_op) begin
          s_nxt.c = cmd;
          s_nxt.widx = 4'h0;
          s_nxt.cnt = cmd.r7_val;
          s_nxt.addr = cmd.r2_val;
          s_nxt.st = lks_pkg::ST_DONE;
          s_nxt.done = 1'b0;
          if (cmd.op == lks_pkg::scan_equal_decrement_op ||
              cmd.op == lks_pkg::scan_equal_increment_op) begin
            if (cmd.r1 == lks_pkg::LKS_COUNT_REG || cmd.r2 == lks_pkg::LKS_COUNT_REG) begin
              s_nxt.chk.invf = 1'b1;
              s_nxt.done = 1'b1;
              s_nxt.st = lks_pkg::ST_IDLE;
            end else if (cmd.r7_val == 16'h0000) begin
              s_nxt.done = 1'b1;
              s_nxt.st = lks_pkg::ST_IDLE;
            end else begin
              s_nxt.st = lks_pkg::ST_SCAN_RD;
              s_nxt.mem_req = 1'b1;
              s_nxt.mem_byte = 1'b1;
              s_nxt.mem_addr = cmd.r2_val;
            end
          end else if (cmd.problem) begin
            s_nxt.chk.priv = 1'b1;
            s_nxt.done = 1'b1;
            s_nxt.st = lks_pkg::ST_IDLE;
          end else if (cmd.op == lks_pkg::set_segment_entry_op && !cmd.xl_on) begin
            s_nxt.chk.invf = 1'b1;
            s_nxt.done = 1'b1;
            s_nxt.st = lks_pkg::ST_IDLE;
          end else begin
            s_nxt.mem_req = 1'b1;
            s_nxt.mem_addr = cmd.ea;
            s_nxt.mem_byte = (cmd.op == lks_pkg::set_storage_key_op);
            unique case (cmd.op)
              lks_pkg::set_level_block_op: s_nxt.st = lks_pkg::ST_SLB_RD;
              lks_pkg::set_storage_key_op: s_nxt.st = lks_pkg::ST_KEY_RD;
              default: s_nxt.st = lks_pkg::ST_SEG_RD1;
            endcase
          end
        end
      end
      lks_pkg::ST_SLB_RD: begin
        if (mem_ack && mem_err) begin
          s_nxt.mem_req = 1'b0;
          s_nxt.chk.isa = 1'b1;
          s_nxt.st = lks_pkg::ST_DONE;
        end else if (mem_ack) begin
          s_nxt.lsb_wr = 1'b1;
          s_nxt.lsb_idx = s_r.widx;
          s_nxt.lsb_dat = mem_rdata;
          if (s_r.widx == lks_pkg::LKS_IAR_WORD) begin
            s_nxt.iar_w = mem_rdata;
          end
          if (s_r.widx == lks_pkg::LKS_LSR_WORD) begin
            s_nxt.lsr_w = mem_rdata;
          end
          if (s_r.widx == 4'(LSB_WORDS - 1)) begin
            s_nxt.mem_req = 1'b0;
            s_nxt.st = lks_pkg::ST_SLB_CHK;
          end else begin
            s_nxt.widx = s_r.widx + 4'h1;
            s_nxt.mem_addr = s_r.mem_addr + lks_pkg::LKS_STEP_WORD;
          end
        end
      end
      lks_pkg::ST_SLB_CHK: begin
        if (s_r.c.opnd[15 - lks_pkg::LKS_LVL_HI_BIT:15 - lks_pkg::LKS_LVL_LO_BIT] ==
            s_r.c.cur_lvl) begin
          s_nxt.cur_upd = 1'b1;
          s_nxt.ind_wr = 1'b1;
          // Indicator n is status bit n counted from the left
          for (int i = 0; i < $bits(s_nxt.ind); i++) begin
            s_nxt.ind[i] = bitn(s_r.lsr_w, i);
          end
        end
        if (s_r.c.am == lks_pkg::LKS_AM_INCR) begin
          s_nxt.reg_wr = 1'b1;
          s_nxt.reg_idx = {1'b0, s_r.c.rb};
          s_nxt.reg_dat = s_r.c.rb_val + lks_pkg::LKS_STEP_WORD;
        end
        if (bitn(s_r.lsr_w, lks_pkg::LKS_TRACE_BIT)) begin
          // Exit sets in-process off: hold trace as for the inhibit bit
          s_nxt.trc = bitn(s_r.c.opnd, lks_pkg::LKS_IT_BIT) ||
                      !bitn(s_r.lsr_w, lks_pkg::LKS_INPROC_BIT);
        end else begin
          s_nxt.trc = 1'b0;
        end
        if (!bitn(s_r.lsr_w, lks_pkg::LKS_SUPV_BIT)) begin
          s_nxt.probe_req = 1'b1;
          s_nxt.probe_addr = s_r.iar_w;
          s_nxt.st = lks_pkg::ST_SLB_CHK2;
        end else begin
          s_nxt.st = lks_pkg::ST_DONE;
        end
      end
      lks_pkg::ST_SLB_CHK2: begin
        s_nxt.chk.prot = probe_bad;
        s_nxt.st = lks_pkg::ST_DONE;
      end
      lks_pkg::ST_KEY_RD: begin
        if (mem_ack) begin
          s_nxt.mem_req = 1'b0;
          s_nxt.chk.isa = mem_err;
          s_nxt.key_wr = !mem_err;
          s_nxt.key_val = mem_rdata[3:0];
          s_nxt.st = lks_pkg::ST_DONE;
        end
      end
      lks_pkg::ST_SEG_RD1: begin
        if (mem_ack && mem_err) begin
          s_nxt.mem_req = 1'b0;
          s_nxt.chk.isa = 1'b1;
          s_nxt.st = lks_pkg::ST_DONE;
        end else if (mem_ack) begin
          s_nxt.seg_hi = mem_rdata;
          s_nxt.mem_addr = s_r.mem_addr + lks_pkg::LKS_STEP_WORD;
          s_nxt.st = lks_pkg::ST_SEG_RD2;
        end
      end
      lks_pkg::ST_SEG_RD2: begin
        if (mem_ack) begin
          s_nxt.mem_req = 1'b0;
          s_nxt.chk.isa = mem_err;
          s_nxt.seg_wr = !mem_err;
          s_nxt.seg_dat = {s_r.seg_hi, mem_rdata};
          s_nxt.st = lks_pkg::ST_DONE;
        end
      end
      lks_pkg::ST_SCAN_RD: begin
        if (mem_ack && mem_err) begin
          s_nxt.mem_req = 1'b0;
          s_nxt.chk.isa = 1'b1;
          s_nxt.st = lks_pkg::ST_SCAN_WB;
        end else if (mem_ack) begin
          s_nxt.ind_wr = 1'b1;
          s_nxt.ind = cmp_ind;
          s_nxt.addr = step(s_r.addr,
                            s_r.c.op == lks_pkg::scan_equal_decrement_op);
          s_nxt.mem_addr = s_nxt.addr;
          if (cmp_eq) begin
            s_nxt.mem_req = 1'b0;
            s_nxt.st = lks_pkg::ST_SCAN_WB;
          end else begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
            // Break only between bytes so count and address agree
            if (s_nxt.cnt == 16'h0000 || irq_pending) begin
              s_nxt.mem_req = 1'b0;
              s_nxt.st = lks_pkg::ST_SCAN_WB;
            end
          end
        end
      end
      lks_pkg::ST_SCAN_WB: begin
        s_nxt.scan_wb = 1'b1;
        s_nxt.st = lks_pkg::ST_DONE;
      end
      lks_pkg::ST_DONE: begin
        s_nxt.done = 1'b1;
        s_nxt.st = lks_pkg::ST_IDLE;
      end
      default: s_nxt.st = lks_pkg::ST_IDLE;
    endcase
    s_nxt.busy = (s_nxt.st != lks_pkg::ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mem_req = s_r.mem_req;
  assign mem_addr = s_r.mem_addr;
  assign mem_byte = s_r.mem_byte;
  assign probe_req = s_r.probe_req;
  assign probe_addr = s_r.probe_addr;
  assign lsb_wr = s_r.lsb_wr;
  assign lsb_lvl = s_r.c.opnd[1:0];
  assign lsb_idx = s_r.lsb_idx;
  assign lsb_dat = s_r.lsb_dat;
  assign cur_upd = s_r.cur_upd;
  assign trace_suppress_flag = s_r.trc;
  assign ind_wr = s_r.ind_wr;
  assign ind = s_r.ind;
  assign reg_wr = s_r.reg_wr;
  assign reg_idx = s_r.reg_idx;
  assign reg_dat = s_r.reg_dat;
  assign scan_wb = s_r.scan_wb;
  assign r2_new = s_r.addr;
  assign r7_new = s_r.cnt;
  assign key_wr = s_r.key_wr;
  assign key_blk = s_r.c.opnd[15:11];
  assign key_val = s_r.key_val;
  assign seg_wr = s_r.seg_wr;
  assign seg_idx = s_r.c.opnd[15:11];
  assign seg_stk = s_r.c.opnd[10:8];
  assign seg_dat = s_r.seg_dat;
  assign xl_done = s_r.xl_done;
  assign xl_phys = s_r.xl_phys;
  assign xl_isa = s_r.xl_isa;
  assign xl_prot = s_r.xl_prot;
  assign busy = s_r.busy;
  assign done = s_r.done;
  assign chk = s_r.chk;

  a_priv_check: assert property (@(posedge clk) disable iff (rst)
    start && !busy && cmd.problem && (cmd.op == lks_pkg::set_level_block_op ||
    cmd.op == lks_pkg::set_storage_key_op) |=> chk.priv && done)
    else $error("privileged op in problem state not checked");
  a_scan_r7_inv: assert property (@(posedge clk) disable iff (rst)
    start && !busy && cmd.op == lks_pkg::scan_equal_increment_op &&
    cmd.r1 == lks_pkg::LKS_COUNT_REG |=> chk.invf ##1 !mem_req)
    else $error("register 7 operand not rejected");
  a_scan_zero_nop: assert property (@(posedge clk) disable iff (rst)
    start && !busy && cmd.op == lks_pkg::scan_equal_decrement_op &&
    cmd.r1 != lks_pkg::LKS_COUNT_REG && cmd.r2 != lks_pkg::LKS_COUNT_REG &&
    cmd.r7_val == 16'h0000 |=> done && !mem_req && !ind_wr)
    else $error("zero count scan touched storage");
  a_scan_count_dec: assert property (@(posedge clk) disable iff (rst)
    s_r.st == lks_pkg::ST_SCAN_RD && mem_ack && !mem_err && !cmp_eq |=>
    r7_new == $past(r7_new) - 16'h0001)
    else $error("scan count not decremented");
  a_scan_eq_keep: assert property (@(posedge clk) disable iff (rst)
    s_r.st == lks_pkg::ST_SCAN_RD && mem_ack && !mem_err && cmp_eq |=>
    r7_new == $past(r7_new) && !mem_req ##1 scan_wb)
    else $error("equal stop changed count");
  a_scan_step_dir: assert property (@(posedge clk) disable iff (rst)
    s_r.st == lks_pkg::ST_SCAN_RD && mem_ack && !mem_err &&
    s_r.c.op == lks_pkg::scan_equal_increment_op |=> r2_new == $past(r2_new) + 16'h0001)
    else $error("scan address did not step up");
  a_lsb_eleven: assert property (@(posedge clk) disable iff (rst)
    s_r.st == lks_pkg::ST_SLB_RD && mem_ack && !mem_err &&
    s_r.widx == 4'(LSB_WORDS - 1) |=> lsb_wr && lsb_idx == 4'(LSB_WORDS - 1) && !mem_req)
    else $error("level block load not ended after last word");
  a_ind_other_lvl: assert property (@(posedge clk) disable iff (rst)
    s_r.st == lks_pkg::ST_SLB_CHK && s_r.c.opnd[1:0] != s_r.c.cur_lvl |=> !ind_wr && !cur_upd)
    else $error("indicators changed for another level");
  a_base_incr: assert property (@(posedge clk) disable iff (rst)
    s_r.st == lks_pkg::ST_SLB_CHK && s_r.c.am == lks_pkg::LKS_AM_INCR |=>
    reg_wr && reg_dat == $past(s_r.c.rb_val) + lks_pkg::LKS_STEP_WORD)
    else $error("base register not advanced by two");
  a_seg_invalid: assert property (@(posedge clk) disable iff (rst)
    xl_req && !bitn(xl.entry, lks_pkg::LKS_SEG_VALID_BIT) |=> xl_done && xl_isa && !xl_prot)
    else $error("invalid segment entry not flagged");
  a_seg_ro_prot: assert property (@(posedge clk) disable iff (rst)
    xl_req && xl.cycle_steal |=> !xl_prot)
    else $error("cycle steal hit read-only check");
  a_seg_xl_off: assert property (@(posedge clk) disable iff (rst)
    start && !busy && cmd.op == lks_pkg::set_segment_entry_op && !cmd.problem &&
    !cmd.xl_on |=> chk.invf && !mem_req)
    else $error("segment load with translator off accepted");

  c_slb_full: cover property (@(posedge clk) disable iff (rst) s_r.st == lks_pkg::ST_SLB_CHK2);
  c_scan_eq: cover property (@(posedge clk) disable iff (rst)
    s_r.st == lks_pkg::ST_SCAN_RD && mem_ack && cmp_eq);
  c_scan_break: cover property (@(posedge clk) disable iff (rst)
    s_r.st == lks_pkg::ST_SCAN_RD && mem_ack && irq_pending && !cmp_eq);
  c_seg_load: cover property (@(posedge clk) disable iff (rst) seg_wr);

endmodule

// *** hw/lks_pkg.sv ***
package lks_pkg;

  localparam int LKS_LSB_WORDS = 11;
  localparam int LKS_DW = 16;

  // Bit positions count from the most significant end, bit 0 leftmost
  localparam int LKS_IT_BIT = 0;
  localparam int LKS_LVL_HI_BIT = 14;
  localparam int LKS_LVL_LO_BIT = 15;
  localparam int LKS_TRACE_BIT = 10;
  localparam int LKS_SUPV_BIT = 8;
  localparam int LKS_INPROC_BIT = 9;
  localparam int LKS_SEG_VALID_BIT = 13;
  localparam int LKS_SEG_RO_BIT = 14;
  localparam int LKS_SEG_PHYS_LSB = 12;
  localparam int LKS_SEG_PHYS_MSB = 7;

  // Word positions inside the level status block in storage
  localparam logic [3:0] LKS_IAR_WORD = 4'h0;
  localparam logic [3:0] LKS_AKR_WORD = 4'h1;
  localparam logic [3:0] LKS_LSR_WORD = 4'h2;

  localparam logic [1:0] LKS_AM_INCR = 2'h1;
  localparam logic [15:0] LKS_STEP_WORD = 16'h0002;
  localparam logic [15:0] LKS_STEP_BYTE = 16'h0001;
  localparam logic [2:0] LKS_COUNT_REG = 3'h7;

  // Indicator positions in the high-order end of the status register, bit 0 leftmost
  localparam int LKS_IND_EVEN = 0;
  localparam int LKS_IND_CARRY = 1;
  localparam int LKS_IND_OVFL = 2;
  localparam int LKS_IND_NEG = 3;
  localparam int LKS_IND_ZERO = 4;

  typedef enum logic [2:0] {
    no_op,
    set_level_block_op,
    set_storage_key_op,
    set_segment_entry_op,
    scan_equal_decrement_op,
    scan_equal_increment_op
  } lks_op_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_SLB_RD,
    ST_SLB_CHK,
    ST_SLB_CHK2,
    ST_KEY_RD,
    ST_SEG_RD1,
    ST_SEG_RD2,
    ST_SCAN_RD,
    ST_SCAN_WB,
    ST_DONE
  } lks_state_t;

  typedef struct packed {
    lks_op_t op;
    logic [15:0] opnd;
    logic [15:0] ea;
    logic [1:0] am;
    logic [1:0] rb;
    logic [15:0] rb_val;
    logic [2:0] r1;
    logic [2:0] r2;
    logic [15:0] r1_val;
    logic [15:0] r2_val;
    logic [15:0] r7_val;
    logic [1:0] cur_lvl;
    logic problem;
    logic xl_on;
  } lks_cmd_t;

  typedef struct packed {
    logic priv;
    logic invf;
    logic isa;
    logic prot;
  } lks_chk_t;

  typedef struct packed {
    logic [15:0] entry;
    logic write;
    logic problem;
    logic cycle_steal;
  } lks_xl_t;

endpackage

// *** sim/lks_mem_model.sv ***
`timescale 1ns/10ps
module lks_mem_model #(
  parameter logic [15:0] LIMIT = 16'h0200
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  // Storage port
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic mem_byte,
  output logic mem_ack,
  output logic mem_err,
  output logic [15:0] mem_rdata,
  // Fetch probe
  input wire logic probe_req,
  input wire logic [15:0] probe_addr,
  output logic probe_bad
);
  logic [15:0] mem [0:255];
  logic [1:0] cnt_r;
  logic [15:0] w;
  logic [7:0] b;
  logic probe_idle_r;

  // No write path at all, so a level block read out stays as it was
  assign w = mem[mem_addr[8:1]];
  assign b = mem_addr[0] ? w[7:0] : w[15:8];
  // The design takes the probe answer while its strobe stands, so answer at once
  assign probe_bad = probe_req ? (probe_addr >= LIMIT) : probe_idle_r;

  // Idle data toggles so a late sample never sees the last word
  always_ff @(posedge clk) begin
    mem_ack <= 1'h0;
    mem_err <= 1'h0;
    mem_rdata <= rst ? 16'h0000 : ~mem_rdata;
    probe_idle_r <= rst ? 1'h0 : ~probe_idle_r;
    if (rst || !mem_req || mem_ack) begin
      cnt_r <= 2'h0;
    end else if (cnt_r == (slow ? 2'h3 : 2'h0)) begin
      mem_ack <= 1'h1;
      mem_err <= mem_addr >= LIMIT;
      mem_rdata <= mem_byte ? {~mem_rdata[15:8], b} : w;
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic start = 1'h0;
  logic irq_pending = 1'h0;
  logic next_instr_done = 1'h0;
  logic slow = 1'h0;
  logic xl_req = 1'h0;
  lks_pkg::lks_cmd_t cmd = '0;
  lks_pkg::lks_cmd_t c;
  lks_pkg::lks_xl_t xl = '0;
  lks_pkg::lks_chk_t chk, chk_acc;
  logic mem_req, mem_byte, mem_ack, mem_err, probe_req, probe_bad, lsb_wr, cur_upd;
  logic trace_suppress_flag, ind_wr, reg_wr, scan_wb, key_wr, seg_wr, xl_done;
  logic xl_isa, xl_prot, busy, done, got_done, got_cur, got_xl, lsb_bad;
  logic [15:0] mem_addr, mem_rdata, probe_addr, lsb_dat, reg_dat, r2_new, r7_new;
  logic [15:0] g_reg, g_r2, g_r7;
  logic [1:0] lsb_lvl, exp_lvl;
  logic [3:0] lsb_idx, key_val;
  logic [4:0] ind, key_blk, seg_idx, last_ind;
  logic [2:0] reg_idx, seg_stk, g_ridx;
  logic [31:0] seg_dat;
  logic [5:0] xl_phys;
  logic [8:0] g_key;
  logic [39:0] g_seg;
  logic [7:0] g_xl;
  int fail_count = 0;
  int n_checks = 0;
  int n_lsb, n_ind, n_reg, n_mem;
  // Translation cases: entry, {write, problem, cycle_steal}, {isa, prot}
  logic [15:0] te [6] = '{16'h016C, 16'h0168, 16'h016E, 16'h016E, 16'h016E, 16'h016E};
  logic [2:0] tm [6] = '{3'h6, 3'h6, 3'h6, 3'h4, 3'h7, 3'h2};
  logic [1:0] tr [6] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0};

  lks_exec uut (.clk, .rst, .start, .cmd, .irq_pending, .next_instr_done, .mem_req, .mem_addr,
    .mem_byte, .mem_ack, .mem_err, .mem_rdata, .probe_req, .probe_addr, .probe_bad, .lsb_wr,
    .lsb_lvl, .lsb_idx, .lsb_dat, .cur_upd, .trace_suppress_flag, .ind_wr, .ind, .reg_wr,
    .reg_idx, .reg_dat, .scan_wb, .r2_new, .r7_new, .key_wr, .key_blk, .key_val, .seg_wr,
    .seg_idx, .seg_stk, .seg_dat, .xl_req, .xl, .xl_done, .xl_phys, .xl_isa, .xl_prot, .busy,
    .done, .chk);

  lks_mem_model mem_m (.clk, .rst, .slow, .mem_req, .mem_addr, .mem_byte, .mem_ack, .mem_err,
    .mem_rdata, .probe_req, .probe_addr, .probe_bad);

  always #5 clk = ~clk;

  // Pulses stand one cycle, so the falling edge sees each exactly once
  always @(negedge clk) begin
    if (!rst) begin
      if (lsb_wr) begin
        n_lsb++;
        if (lsb_lvl !== exp_lvl || lsb_dat !== mem_m.mem[cmd.ea[8:1] + lsb_idx]) lsb_bad = 1;
      end
      if (ind_wr) begin
        n_ind++;
        last_ind = ind;
      end
      if (reg_wr) begin
        n_reg++;
        {g_ridx, g_reg} = {reg_idx, reg_dat};
      end
      if (scan_wb) {g_r2, g_r7} = {r2_new, r7_new};
      if (key_wr) g_key = {key_blk, key_val};
      if (seg_wr) g_seg = {seg_idx, seg_stk, seg_dat};
      if (xl_done) {got_xl, g_xl} = {1'h1, xl_phys, xl_isa, xl_prot};
      if (cur_upd) got_cur = 1;
      if (mem_req) n_mem++;
      if (done) got_done = 1;
      chk_acc = chk_acc | chk;
    end
  end

  task automatic check(input logic [71:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic note(input string s);
    $display("test %s ended, %0d mismatches so far", s, fail_count);
  endtask

  function automatic lks_pkg::lks_cmd_t mk(input lks_pkg::lks_op_t op, input logic [15:0] o, a);
    lks_pkg::lks_cmd_t k;
    k = '0;
    k.op = op;
    k.opnd = o;
    k.ea = a;
    k.r1 = 3'h1;
    k.r2 = 3'h2;
    k.xl_on = 1'h1;
    return k;
  endfunction

  // Indicators of op2 - op1 as {zero, neg, ovfl, carry, even}
  function automatic logic [4:0] exp_ind(input logic [7:0] a, b);
    logic [8:0] d;
    d = {1'h0, a} - {1'h0, b};
    return {d[7:0] == 8'h00, d[7], (a[7] != b[7]) && (d[7] != a[7]), d[8], ~d[0]};
  endfunction

  // Start is held one cycle only; the design ignores it while busy
  task automatic run(input lks_pkg::lks_cmd_t k);
    int n;
    @(negedge clk);
    cmd = k;
    start = 1;
    {n_lsb, n_ind, n_reg, n_mem} = '0;
    {got_done, got_cur, lsb_bad, chk_acc} = '0;
    @(negedge clk);
    start = 0;
    n = 0;
    while (got_done !== 1'h1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    check({got_done, busy}, 2'h2);
  endtask

  task automatic nid();
    next_instr_done = 1;
    @(negedge clk);
    next_instr_done = 0;
    @(negedge clk);
  endtask

  initial begin
    #100000;
    fail_count++;
    conclude();
  end

  initial begin
    for (int i = 0; i < 256; i++) mem_m.mem[i] = 16'h1000 + 16'(i);
    mem_m.mem[8'h22] = 16'hA0E0;
    mem_m.mem[8'h42] = 16'h00A0;
    mem_m.mem[8'h62] = 16'h0040;
    mem_m.mem[8'h80] = 16'h3C5A;
    mem_m.mem[8'h88] = 16'h0156;
    mem_m.mem[8'h89] = 16'h0000;
    mem_m.mem[8'hA8] = 16'h8011;
    mem_m.mem[8'hA9] = 16'h4422;
    repeat (6) @(negedge clk);
    rst = 0;
    c = mk(lks_pkg::set_level_block_op, 16'h8002, 16'h0040);
    c.am = 2'h1;
    c.rb = 2'h3;
    c.rb_val = 16'h1234;
    exp_lvl = 2'h2;
    run(c);
    check({n_lsb, lsb_bad}, {32'h0000_000B, 1'h0});
    check({got_cur, n_ind}, 0);
    check({g_ridx, g_reg}, {3'h3, 16'h1236});
    check(trace_suppress_flag, 1);
    nid();
    check(trace_suppress_flag, 0);
    note("level block to other level");
    c = mk(lks_pkg::set_level_block_op, 16'h0001, 16'h0040);
    c.cur_lvl = 2'h1;
    exp_lvl = 2'h1;
    slow = 1;
    run(c);
    slow = 0;
    check({n_lsb, lsb_bad, got_cur, n_reg}, {32'h0000_000B, 2'h1, 32'h0});
    check(trace_suppress_flag, 0);
    check(last_ind, 5'h05);
    c = mk(lks_pkg::set_level_block_op, 16'h0000, 16'h0080);
    exp_lvl = 2'h0;
    run(c);
    check(trace_suppress_flag, 1);
    nid();
    c = mk(lks_pkg::set_level_block_op, 16'h0003, 16'h00C0);
    exp_lvl = 2'h3;
    run(c);
    check(chk_acc.prot, 1);
    note("level block same level, exit, bad fetch");
    for (int i = 1; i < 4; i++) begin
      c = mk(lks_pkg::lks_op_t'(i), 16'h0000, 16'h0040);
      c.problem = 1;
      run(c);
      check({chk_acc, n_mem}, {4'h8, 32'h0});
    end
    c = mk(lks_pkg::set_storage_key_op, 16'h9800, 16'h0101);
    run(c);
    check(g_key, {5'h13, 4'hA});
    c.ea = 16'h0300;
    run(c);
    check(chk_acc, 4'h2);
    c = mk(lks_pkg::set_segment_entry_op, 16'hFD00, 16'h0110);
    run(c);
    check(g_seg, {5'h1F, 3'h5, 32'h0156_0000});
    c.xl_on = 0;
    run(c);
    check(chk_acc, 4'h4);
    note("privilege, key and segment loads");
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      xl_req = 1;
      xl = {te[i], tm[i]};
      got_xl = 0;
      @(negedge clk);
      xl_req = 0;
      repeat (2) @(negedge clk);
      check({got_xl, g_xl}, {1'h1, 6'h2D, tr[i]});
    end
    note("translation checks");
    c = mk(lks_pkg::scan_equal_increment_op, 16'h0000, 16'h0000);
    c.r1_val = 16'h0044;
    c.r2_val = 16'h0150;
    c.r7_val = 16'h0005;
    run(c);
    check({g_r2, g_r7}, {16'h0153, 16'h0003});
    check({last_ind, n_ind}, {5'h11, 32'h3});
    c.op = lks_pkg::scan_equal_decrement_op;
    c.r1_val = 16'h0001;
    c.r2_val = 16'h0151;
    c.r7_val = 16'h0002;
    run(c);
    check({g_r2, g_r7}, {16'h014F, 16'h0000});
    check(last_ind, exp_ind(8'h80, 8'h01));
    c.r7_val = 16'h0000;
    run(c);
    check({n_mem, n_ind}, 0);
    c.op = lks_pkg::scan_equal_increment_op;
    c.r1_val = 16'h00FF;
    c.r2_val = 16'h0150;
    c.r7_val = 16'h0004;
    irq_pending = 1;
    run(c);
    irq_pending = 0;
    check(g_r7 + (g_r2 - 16'h0150), 4);
    c.r2_val = g_r2;
    c.r7_val = g_r7;
    run(c);
    check({g_r2, g_r7}, {16'h0154, 16'h0000});
    for (int i = 0; i < 2; i++) begin
      c.r1 = i ? 3'h1 : 3'h7;
      c.r2 = i ? 3'h7 : 3'h2;
      run(c);
      check({chk_acc, n_mem}, {4'h4, 32'h0});
    end
    note("byte scans");
    conclude();
  end
endmodule
